// file: ebm_regs.svh
// Constants for the external bus master and sampling logic
`ifndef EBM_REGS_SVH
`define EBM_REGS_SVH
// Address bus width, bit 0 is the most significant line
`define EBM_ADDR_W 32
// Beats in one burst transfer
`define EBM_BURST_BEATS 4
// Cycles the bus monitor waits for a termination before raising an error
`define EBM_MON_CYCLES 64
// Flip-flops in each pin synchroniser
`define EBM_SYNC_STAGES 2
// Level of an active-low line while negated
`define EBM_NEGATED 1'b1
`endif

// file: ebm_pkg.sv
// Types shared by the external bus master and its testbench
package ebm_pkg;
  // Transaction asked for by an internal master
  typedef struct packed {
    logic [0:31] addr;     // Address, bit 0 most significant
    logic [1:0] size;      // Transfer size code, bit 1 on the high size line when card is low
    logic read;            // High for a read from the slave
    logic burst;           // Burst transfer
    logic card;            // Slave handled by the card interface
    logic card_space;      // Card address space select
    logic upm_two;         // Slave access run by the second user machine
  } req_s;
  // Transaction seen from an external master
  typedef struct packed {
    logic [0:31] addr;
    logic [1:0] size;
    logic read;
    logic burst;
  } snoop_s;
  // Bus cycle states of the device as master
  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_NEGATE} bus_state_e;
endpackage

// file: ebm_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ns
module ebm_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta; // First stage, read only by the second

  // Both stages, frozen while the clock enable is low
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta <= INIT;
      q <= INIT;
    end
    else if (ce)
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// file: ebm_master.sv
// External bus signalling: master cycles and sampling of external masters
`timescale 1ns/1ns
`include "ebm_regs.svh"
module ebm_master import ebm_pkg::*; #(
  parameter int BURST_BEATS = `EBM_BURST_BEATS,
  parameter int MON_CYCLES = `EBM_MON_CYCLES
) (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic BUS_GRANT,
  input wire logic REQ_VALID,
  input wire req_s REQ,
  output logic REQ_READY,
  output logic DONE,
  output logic DONE_ERROR,
  input wire logic MEM_STROBE_FIVE,
  output logic SNOOP_VALID,
  output snoop_s SNOOP,
  input wire logic [0:31] ADDR_I,
  output logic [0:31] ADDR_O,
  output logic ADDR_OE,
  input wire logic XFER_SIZE_BIT_HI_I,
  output logic XFER_SIZE_BIT_HI_O,
  output logic XFER_SIZE_BIT_HI_OE,
  input wire logic XFER_SIZE_BIT_LO_I,
  output logic XFER_SIZE_BIT_LO_O,
  output logic XFER_SIZE_BIT_LO_OE,
  input wire logic RD_WR_I,
  output logic RD_WR_O,
  output logic RD_WR_OE,
  input wire logic BURST_N_I,
  output logic BURST_N_O,
  output logic BURST_N_OE,
  output logic BURST_BEAT_PENDING_N_O,
  output logic BURST_BEAT_PENDING_N_OE,
  input wire logic XFER_BEGIN_N_I,
  output logic XFER_BEGIN_N_O,
  output logic XFER_BEGIN_N_OE,
  input wire logic XFER_ACK_N_I,
  input wire logic XFER_ERROR_ACK_N_I,
  output logic XFER_ERROR_ACK_N_O,
  output logic XFER_ERROR_ACK_N_OE
);
  localparam int BW = $clog2(BURST_BEATS + 1);
  localparam int MW = $clog2(MON_CYCLES + 1);
  localparam int SW = `EBM_ADDR_W + 7;

  bus_state_e state;        // Master cycle state
  req_s cur;                // Transaction being run
  logic drive_oe;           // Device owns and drives the bus pins
  logic start_n;            // Transfer start level driven
  logic burst_n;            // Burst level driven
  logic pend_n;             // Beat-pending level driven
  logic size_hi;            // Level on the high size line
  logic [BW-1:0] beats_left; // Beats still to be acknowledged
  logic [MW-1:0] mon_cnt;   // Cycles waited for a termination
  logic tea_drive;          // Device pulls the error line low
  logic [SW-1:0] sync_q;    // Synchronised pin inputs
  logic start_prev;         // Synchronised transfer start, one cycle older
  logic accept;             // Request taken this cycle
  logic ack_seen;           // Acknowledge seen on the bus
  logic err_seen;           // Error termination, from a slave or the monitor
  logic mon_fire;           // Monitor ran out of time
  logic last_ack;           // Final beat acknowledged
  snoop_s seen;             // Synchronised external transaction fields

  // Pin inputs pass two flip-flops before use
  ebm_sync #(.W(SW), .INIT({SW{`EBM_NEGATED}})) u_sync (
    .clk(CLOCK),
    .rst(RESET),
    .ce(CE),
    .d({ADDR_I, XFER_SIZE_BIT_HI_I, XFER_SIZE_BIT_LO_I, RD_WR_I, BURST_N_I,
        XFER_BEGIN_N_I, XFER_ACK_N_I, XFER_ERROR_ACK_N_I}),
    .q(sync_q)
  );

  // Decode of the synchronised inputs
  always_comb
  begin
    seen.addr = sync_q[SW-1 -: `EBM_ADDR_W];
    seen.size = sync_q[6:5];
    seen.read = sync_q[4];
    seen.burst = ~sync_q[3];
    ack_seen = ~sync_q[1];
    mon_fire = (mon_cnt == MW'(MON_CYCLES - 1));
    err_seen = ~sync_q[0] | mon_fire;
  end

  // Handshake with the internal masters
  assign REQ_READY = (state == ST_IDLE) && BUS_GRANT;
  assign accept = REQ_READY && REQ_VALID && CE;
  assign last_ack = (state == ST_DATA) && ack_seen && (beats_left == BW'(1));

  // Cycle sequencing
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      state <= ST_IDLE;
    else if (CE)
    begin
      case (state)
        ST_IDLE:
          if (accept)
            state <= ST_START;
        ST_START:
          state <= ST_DATA;
        ST_DATA:
          // Error ends the cycle whatever the acknowledge shows
          if (err_seen || last_ack)
            state <= ST_NEGATE;
        ST_NEGATE:
          state <= ST_IDLE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Latch the transaction and the levels it puts on the pins
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      cur <= '0;
      size_hi <= 1'b0;
      burst_n <= `EBM_NEGATED;
    end
    else if (CE && accept)
    begin
      cur <= REQ;
      size_hi <= REQ.card ? REQ.card_space : REQ.size[1];
      burst_n <= ~REQ.burst;
    end
  end

  // Ownership of the pins, floating from reset until a cycle begins
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      drive_oe <= 1'b0;
    else if (CE)
    begin
      if (accept)
        drive_oe <= 1'b1;
      else if (state == ST_NEGATE)
        drive_oe <= 1'b0;
    end
  end

  // Transfer start: one cycle low at the start of each bus cycle
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      start_n <= `EBM_NEGATED;
    else if (CE)
      start_n <= ~accept;
  end

  // Beat count and beat-pending line
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      beats_left <= '0;
      pend_n <= `EBM_NEGATED;
    end
    else if (CE)
    begin
      // Count acks even while the pin serves as a strobe
      if (accept)
        beats_left <= REQ.burst ? BW'(BURST_BEATS) : BW'(1);
      else if (state == ST_DATA && ack_seen)
        beats_left <= beats_left - BW'(1);
      // The second user machine owns the pin as a strobe from the first driven cycle
      if (accept ? REQ.upm_two : (cur.upm_two && drive_oe))
        pend_n <= MEM_STROBE_FIVE;
      else if (accept)
        pend_n <= ~(REQ.burst && BURST_BEATS > 1);
      // Negate once the next beat is the final one, or when an error ends the cycle
      else if (state == ST_DATA && (err_seen || (ack_seen && beats_left <= BW'(2))))
        pend_n <= `EBM_NEGATED;
      else if (state == ST_NEGATE)
        pend_n <= `EBM_NEGATED;
    end
  end

  // Bus monitor: raises an error when no termination arrives in time
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      mon_cnt <= '0;
      tea_drive <= 1'b0;
    end
    else if (CE)
    begin
      if (state == ST_DATA && !ack_seen && !err_seen)
        mon_cnt <= mon_cnt + MW'(1);
      else
        mon_cnt <= '0;
      tea_drive <= (state == ST_DATA) && mon_fire;
    end
  end

  // Completion report to the internal master
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      DONE <= 1'b0;
      DONE_ERROR <= 1'b0;
    end
    else if (CE)
    begin
      DONE <= (state == ST_DATA) && (err_seen || last_ack);
      DONE_ERROR <= (state == ST_DATA) && err_seen;
    end
  end

  // Detect a cycle started by an external master and capture its fields
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      start_prev <= `EBM_NEGATED;
      SNOOP_VALID <= 1'b0;
      SNOOP <= '0;
    end
    else if (CE)
    begin
      start_prev <= sync_q[2];
      SNOOP_VALID <= start_prev && !sync_q[2] && !drive_oe;
      if (start_prev && !sync_q[2] && !drive_oe)
        SNOOP <= seen;
    end
  end

  // Pin drive
  assign ADDR_O = cur.addr;
  assign XFER_SIZE_BIT_HI_O = size_hi;
  assign XFER_SIZE_BIT_LO_O = cur.size[0];
  assign RD_WR_O = cur.read;
  assign BURST_N_O = burst_n;
  assign BURST_BEAT_PENDING_N_O = pend_n;
  assign XFER_BEGIN_N_O = start_n;
  assign XFER_ERROR_ACK_N_O = 1'b0;
  assign XFER_ERROR_ACK_N_OE = tea_drive;
  assign ADDR_OE = drive_oe;
  assign XFER_SIZE_BIT_HI_OE = drive_oe;
  assign XFER_SIZE_BIT_LO_OE = drive_oe;
  assign RD_WR_OE = drive_oe;
  assign BURST_N_OE = drive_oe;
  assign BURST_BEAT_PENDING_N_OE = drive_oe;
  assign XFER_BEGIN_N_OE = drive_oe;

  // Steps of a master cycle
  sequence s_taken;
    accept;
  endsequence
  sequence s_started;
    !start_n && drive_oe;
  endsequence

  a_start_one_cycle: assert property (@(posedge CLOCK) disable iff (RESET || !CE)
    s_taken |=> s_started ##1 start_n) else $error("transfer start not one cycle");
  a_start_owned_bus: assert property (@(posedge CLOCK) disable iff (RESET)
    !start_n |-> drive_oe) else $error("transfer start without ownership");
  a_release_start_high: assert property (@(posedge CLOCK) disable iff (RESET)
    $fell(drive_oe) |-> start_n && $past(start_n)) else $error("bus released with start low");
  a_reset_floats: assert property (@(posedge CLOCK)
    RESET |=> !drive_oe && !tea_drive) else $error("pins driven after reset");
  a_dir_matches: assert property (@(posedge CLOCK) disable iff (RESET || !CE)
    accept |=> RD_WR_O == $past(REQ.read)) else $error("direction wrong");
  a_card_space: assert property (@(posedge CLOCK) disable iff (RESET)
    (state == ST_START && cur.card) |-> size_hi == cur.card_space)
    else $error("card space not on size line");
  a_pend_last_beat: assert property (@(posedge CLOCK) disable iff (RESET)
    (last_ack && !cur.upm_two) |-> pend_n) else $error("beat pending on last beat");
  a_error_ends_cycle: assert property (@(posedge CLOCK) disable iff (RESET || !CE)
    (state == ST_DATA && err_seen) |=> state == ST_NEGATE ##1 !drive_oe)
    else $error("error did not end cycle");
  a_snoop_detect: assert property (@(posedge CLOCK) disable iff (RESET || !CE)
    ($fell(sync_q[2]) && !drive_oe) |=> SNOOP_VALID && SNOOP == $past(seen))
    else $error("external start missed");
endmodule

// file: ebm_slave.sv
// Partner model: a slave that answers master cycles with acks or errors
`timescale 1ns/1ns
module ebm_slave #(
  parameter int BEATS = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic begin_n,
  input wire logic burst_n,
  input wire logic [1:0] mode,
  input wire logic [3:0] wait_cycles,
  output logic ack_n,
  output logic err_n
);
  int beats; // Beats still owed in this cycle
  initial
  begin
    ack_n = 1'b1;
    err_n = 1'b1;
  end
  // Mode 0 acks, mode 1 answers with an error, mode 2 stays silent
  always @(posedge clk)
  begin
    if (!rst && begin_n === 1'b0)
    begin
      beats = (burst_n === 1'b0) ? BEATS : 1;
      while (beats > 0 && mode != 2'h2)
      begin
        repeat (wait_cycles) @(posedge clk);
        if (mode == 2'h1)
        begin
          err_n <= 1'b0; // Error ends the cycle
          beats = 0;
        end
        else
        begin
          ack_n <= 1'b0; // One low cycle per beat
          beats--;
        end
        @(posedge clk);
        ack_n <= 1'b1; // Back to the pull-up level
        err_n <= 1'b1;
        if (beats > 0)
          @(posedge clk);
      end
    end
  end
endmodule

// file: tb_top.sv
// Testbench for the external bus master and sampling logic
`timescale 1ns/1ns
module tb_top import ebm_pkg::*;;
  logic CLOCK = 1'b0;
  logic RESET = 1'b1;
  logic BUS_GRANT = 1'b1;
  logic CE = 1'b1;
  logic REQ_VALID = 1'b0;
  logic MEM_STROBE_FIVE = 1'b0;
  req_s REQ = '0;
  logic REQ_READY, DONE, DONE_ERROR, SNOOP_VALID;
  snoop_s SNOOP;
  logic [0:31] ADDR_O;
  logic ADDR_OE, hi_o, hi_oe, lo_o, lo_oe, rw_o, rw_oe, bst_o, bst_oe;
  logic bbp_o, bbp_oe, beg_o, beg_oe, ack_w, slv_ack, slv_err, tea_o, tea_oe;
  // External master drive in the device's place
  logic [0:31] ext_addr = '0;
  logic [3:0] ext = 4'hf; // hi, lo, rd_wr, burst_n
  logic ext_beg = 1'b1;
  logic [1:0] mode = 2'h0;
  logic [3:0] wcyc = 4'h0;
  int num_errors = 0;
  int n_compared = 0;
  int n_acks = 0;
  int n_tea = 0;
  // Resolved pin levels; start line falls back to ext_beg, undriven error line sits at the pull-up
  wire [0:31] addr_w = ADDR_OE ? ADDR_O : ext_addr;
  wire beg_w = beg_oe ? beg_o : ext_beg;
  wire bst_w = bst_oe ? bst_o : ext[0];
  wire tea_w = (tea_oe ? tea_o : 1'b1) & slv_err;
  always #5 CLOCK = ~CLOCK;
  // Count acks and monitor error pulses
  always @(posedge CLOCK)
  begin
    if (slv_ack === 1'b0)
      n_acks++;
    if (tea_oe === 1'b1)
      n_tea++;
  end
  ebm_master #(.BURST_BEATS(4), .MON_CYCLES(8)) i_ebm_master (.CLOCK(CLOCK), .RESET(RESET),
    .CE(CE), .BUS_GRANT(BUS_GRANT), .REQ_VALID(REQ_VALID), .REQ(REQ),
    .REQ_READY(REQ_READY), .DONE(DONE), .DONE_ERROR(DONE_ERROR),
    .MEM_STROBE_FIVE(MEM_STROBE_FIVE), .SNOOP_VALID(SNOOP_VALID), .SNOOP(SNOOP),
    .ADDR_I(addr_w), .ADDR_O(ADDR_O), .ADDR_OE(ADDR_OE),
    .XFER_SIZE_BIT_HI_I(hi_oe ? hi_o : ext[3]), .XFER_SIZE_BIT_HI_O(hi_o),
    .XFER_SIZE_BIT_HI_OE(hi_oe), .XFER_SIZE_BIT_LO_I(lo_oe ? lo_o : ext[2]),
    .XFER_SIZE_BIT_LO_O(lo_o), .XFER_SIZE_BIT_LO_OE(lo_oe),
    .RD_WR_I(rw_oe ? rw_o : ext[1]), .RD_WR_O(rw_o), .RD_WR_OE(rw_oe),
    .BURST_N_I(bst_w), .BURST_N_O(bst_o), .BURST_N_OE(bst_oe),
    .BURST_BEAT_PENDING_N_O(bbp_o), .BURST_BEAT_PENDING_N_OE(bbp_oe),
    .XFER_BEGIN_N_I(beg_w), .XFER_BEGIN_N_O(beg_o), .XFER_BEGIN_N_OE(beg_oe),
    .XFER_ACK_N_I(slv_ack), .XFER_ERROR_ACK_N_I(tea_w),
    .XFER_ERROR_ACK_N_O(tea_o), .XFER_ERROR_ACK_N_OE(tea_oe));
  ebm_slave #(.BEATS(4)) i_ebm_slave (.clk(CLOCK), .rst(RESET), .begin_n(beg_w),
    .burst_n(bst_w), .mode(mode), .wait_cycles(wcyc), .ack_n(slv_ack), .err_n(slv_err));
  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One master cycle, pins checked in the first driven cycle and at the end
  task automatic master(input req_s r, input logic [1:0] m, input logic [3:0] w,
    input logic exp_err);
    int n;
    int acks0;
    int tea0;
    n = 0;
    mode = m;
    wcyc = w;
    REQ = r;
    REQ_VALID = 1'b1;
    acks0 = n_acks;
    tea0 = n_tea;
    while (REQ_READY !== 1'b1 && n < 50)
    begin
      @(negedge CLOCK);
      n++;
    end
    @(negedge CLOCK);
    REQ_VALID = 1'b0;
    check("addr_oe", {hi_oe, lo_oe, rw_oe, bst_oe, ADDR_OE, bbp_oe}, 32'h3f);
    check("addr", ADDR_O, r.addr);
    check("size_hi", hi_o, r.card ? r.card_space : r.size[1]);
    check("size_lo", lo_o, r.size[0]);
    check("rd_wr", rw_o, r.read);
    check("burst_n", bst_o, !r.burst);
    check("begin_n", {beg_oe, beg_o}, 32'h2);
    if (r.upm_two)
      check("strobe", bbp_o, MEM_STROBE_FIVE);
    else if (r.burst)
      check("pending", bbp_o, 1'b0);
    @(negedge CLOCK);
    check("begin_one", beg_o, 1'b1);
    n = 0;
    while (DONE !== 1'b1 && n < 200)
    begin
      @(negedge CLOCK);
      n++;
    end
    check("done_err", {DONE, DONE_ERROR}, {1'b1, exp_err});
    check("begin_end", beg_o, 1'b1);
    if (r.burst && !r.upm_two)
      check("pend_last", bbp_o, 1'b1);
    if (m == 2'h0)
      check("acks", n_acks - acks0, r.burst ? 4 : 1);
    check("tea_pin", {tea_oe, tea_o}, {m == 2'h2, 1'b0});
    @(negedge CLOCK);
    check("tea", n_tea - tea0, m == 2'h2);
    check("released", {ADDR_OE, beg_oe}, 32'h0);
  endtask
  // External master starts a cycle; the device samples it
  task automatic snoop(input logic [31:0] a, input logic [3:0] f);
    int n;
    ext_addr = a;
    ext = f;
    ext_beg = 1'b0;
    @(negedge CLOCK);
    ext_beg = 1'b1;
    n = 1;
    while (SNOOP_VALID !== 1'b1 && n < 8)
    begin
      @(negedge CLOCK);
      n++;
    end
    check("snoop_lat", n, 3);
    check("snoop", {SNOOP.size, SNOOP.read, SNOOP.burst}, {f[3:1], !f[0]});
    check("snoop_addr", SNOOP.addr, a);
    check("snoop_msb", SNOOP.addr[0], a[31]);
    ext_addr = ~a;
    ext = ~f;
    @(negedge CLOCK);
    check("snoop_once", SNOOP_VALID, 1'b0);
  endtask
  // Without grant, or with the clock enable low, no cycle starts
  task automatic no_grant();
    BUS_GRANT = 1'b0;
    REQ_VALID = 1'b1;
    repeat (4) @(negedge CLOCK);
    check("ready", REQ_READY, 1'b0);
    check("float", {ADDR_OE, beg_oe}, 32'h0);
    BUS_GRANT = 1'b1;
    CE = 1'b0;
    repeat (3) @(negedge CLOCK);
    check("frozen", {ADDR_OE, beg_oe, beg_o, DONE}, 32'h2);
    REQ_VALID = 1'b0;
    CE = 1'b1;
    @(negedge CLOCK);
  endtask
  initial
  begin
    #50000;
    num_errors++;
    stop_test();
  end
  initial
  begin
    repeat (10) @(negedge CLOCK);
    check("reset_oe", {ADDR_OE, hi_oe, lo_oe, rw_oe, bst_oe, beg_oe}, 32'h0);
    RESET = 1'b0;
    @(negedge CLOCK);
    check("idle_oe", {ADDR_OE, beg_oe, beg_o}, 32'h1);
    no_grant();
    for (int i = 0; i < 4; i++)
      master(req_s'{32'h8000_0001 << i, i[1:0], i[0], 1'b0, 1'b0, 1'b0, 1'b0}, 2'h0,
        i[3:0], 1'b0);
    master(req_s'{32'h1234_5678, 2'h0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0}, 2'h0, 4'h0, 1'b0);
    master(req_s'{32'h0000_0f00, 2'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0}, 2'h0, 4'h2, 1'b0);
    master(req_s'{32'h4000_0004, 2'h0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0}, 2'h0, 4'h0, 1'b0);
    master(req_s'{32'h0a0b_0c0d, 2'h2, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1}, 2'h0, 4'h1, 1'b0);
    MEM_STROBE_FIVE = 1'b1;
    master(req_s'{32'h0a0b_0c10, 2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1}, 2'h0, 4'h1, 1'b0);
    MEM_STROBE_FIVE = 1'b0;
    master(req_s'{32'hdead_0000, 2'h0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0}, 2'h1, 4'h1, 1'b1);
    master(req_s'{32'h0000_beef, 2'h3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0}, 2'h2, 4'h0, 1'b1);
    snoop(32'h8000_0002, 4'b0110);
    snoop(32'h0000_0001, 4'b1011);
    stop_test();
  end
endmodule
